// ### common/fsp_pkg.sv
package fsp_pkg;
   localparam int ADDR_W = 18;
   localparam int DATA_W = 16;
   localparam logic [17:0] ADR_5555 = 18'h05555;
   localparam logic [17:0] ADR_2AAA = 18'h02aaa;
   localparam logic [17:0] ADR_55 = 18'h00055;
   localparam logic [17:0] ADR_ZERO = 18'h00000;
   localparam logic [7:0] CMD_AA = 8'haa;
   localparam logic [7:0] CMD_55 = 8'h55;
   localparam logic [7:0] CMD_PROG = 8'ha0;
   localparam logic [7:0] CMD_ERS = 8'h80;
   localparam logic [7:0] CMD_ID = 8'h90;
   localparam logic [7:0] CMD_QRY = 8'h98;
   localparam logic [7:0] CMD_EXIT = 8'hf0;
   localparam logic [7:0] CMD_SEC = 8'h30;
   localparam logic [7:0] CMD_BLK = 8'h50;
   localparam logic [7:0] CMD_CHIP = 8'h10;
   localparam int BIT_POLL = 7;
   localparam int BIT_TOG = 6;
   localparam int CLK_NS = 40;
   // Strobe low time: well above 5 ns glitch filter
   localparam int GLITCH_NS = 5;
   localparam int STB_CYC = (GLITCH_NS + CLK_NS - 1) / CLK_NS + 1;
   localparam int SETTLE_NS = 1000;
   localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
   localparam int RD_CYC = 2;
   localparam int EXTRA_READS = 2;
   typedef enum logic [2:0] {FSP_OP_READ, FSP_OP_PROG, FSP_OP_SEC,
      FSP_OP_BLK, FSP_OP_CHIP, FSP_OP_ID, FSP_OP_QRY, FSP_OP_EXIT
   } fsp_op_t;
   typedef struct packed {
      fsp_op_t op;
      logic [17:0] addr;
      logic [15:0] data;
      logic vendor;
   } fsp_req_t;
   typedef struct packed {
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic dq_oe;
      logic [17:0] addr;
      logic [15:0] dq;
   } fsp_pins_t;
endpackage

// ### rtl/fsp_bus_cycle.sv
`timescale 1ns/1ps
// ----------------------------------------
// One bus cycle: write or read on the pins
// ----------------------------------------
module fsp_bus_cycle
   import fsp_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_start,
   input wire logic i_wr,
   input wire logic [17:0] i_addr,
   input wire logic [15:0] i_data,
   input wire logic [15:0] i_dq,
   output fsp_pkg::fsp_pins_t o_pins,
   output logic o_done,
   output logic [15:0] o_rdata
);
   typedef enum {FSP_BC_IDLE, FSP_BC_ACT, FSP_BC_REC} fsp_bc_t;
   fsp_bc_t st_r, st_nxt;
   logic [3:0] cnt_r, cnt_nxt;
   fsp_pins_t pins_r, pins_nxt;
   logic done_r, done_nxt;
   logic [15:0] rd_r, rd_nxt;

   // Strobe held low several cycles so glitch filter never eats it
   always_comb
   begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      pins_nxt = pins_r;
      done_nxt = 1'b0;
      rd_nxt = rd_r;
      unique case (st_r)
         FSP_BC_IDLE:
         begin
            if (i_start)
            begin
               pins_nxt.addr = i_addr;
               pins_nxt.dq = i_data;
               pins_nxt.ce_n = 1'b0;
               // Gate high while writing, else write inhibited
               pins_nxt.oe_n = i_wr;
               pins_nxt.we_n = ~i_wr;
               pins_nxt.dq_oe = i_wr;
               cnt_nxt = 4'(i_wr ? STB_CYC : RD_CYC);
               st_nxt = FSP_BC_ACT;
            end
         end
         FSP_BC_ACT:
         begin
            if (cnt_r == 4'h0)
            begin
               // Rising strobe latches data
               rd_nxt = i_dq;
               pins_nxt.we_n = 1'b1;
               pins_nxt.oe_n = 1'b1;
               pins_nxt.ce_n = 1'b1;
               st_nxt = FSP_BC_REC;
            end
            else
               cnt_nxt = cnt_r - 4'h1;
         end
         FSP_BC_REC:
         begin
            pins_nxt.dq_oe = 1'b0;
            done_nxt = 1'b1;
            st_nxt = FSP_BC_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         st_r <= FSP_BC_IDLE;
         cnt_r <= 4'h0;
         // Pins parked: select, gate and strobe high, bus released
         pins_r <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, dq_oe: 1'b0,
            addr: 18'h00000, dq: 16'h0000};
         done_r <= 1'b0;
         rd_r <= 16'h0000;
      end
      else
      begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         pins_r <= pins_nxt;
         done_r <= done_nxt;
         rd_r <= rd_nxt;
      end
   end

   assign o_pins = pins_r;
   assign o_done = done_r;
   assign o_rdata = rd_r;

   chk_we_pulse_len: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      $fell(pins_r.we_n) |-> !pins_r.we_n [*2])
      else $error("write strobe shorter than filter");
   chk_write_gate: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      !pins_r.we_n |-> pins_r.oe_n && !pins_r.ce_n)
      else $error("write with gate low or select high");
endmodule // fsp_bus_cycle

// ### rtl/fsp_host.sv
`timescale 1ns/1ps
// ----------------------------------------
// Flash command host: sequences and polling
// ----------------------------------------
module fsp_host
   import fsp_pkg::*;
#(
   parameter int SETTLE = SETTLE_CYC
)
(
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_req_valid,
   input fsp_pkg::fsp_req_t i_req,
   input wire logic [15:0] i_dq,
   output logic o_req_ready,
   output logic o_done,
   output logic o_fail,
   output logic [15:0] o_rdata,
   output logic o_ce_n,
   output logic o_oe_n,
   output logic o_we_n,
   output logic o_dq_oe,
   output logic [17:0] o_addr,
   output logic [15:0] o_dq
);
   import fsp_pkg::*;

   typedef enum {FSP_IDLE, FSP_SEQ, FSP_POLL, FSP_CONF, FSP_SETTLE,
      FSP_RD} fsp_st_t;

   fsp_st_t st_r, st_nxt;
   fsp_req_t req_r, req_nxt;
   logic [2:0] idx_r, idx_nxt;
   logic [1:0] conf_r, conf_nxt;
   logic [15:0] prev_r, prev_nxt;
   logic first_r, first_nxt;
   logic [15:0] wait_r, wait_nxt;
   logic go_r, go_nxt;
   logic done_r, done_nxt;
   logic fail_r, fail_nxt;
   logic [15:0] rdat_r, rdat_nxt;
   logic ready_r, ready_nxt;
   logic bc_wr;
   logic [17:0] bc_addr;
   logic [15:0] bc_data;
   logic [2:0] seq_len;
   logic bc_done;
   logic [15:0] bc_rd;
   fsp_pins_t pins;
   logic busy_view;

   fsp_bus_cycle u_bc (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_start(go_r),
      .i_wr(bc_wr),
      .i_addr(bc_addr),
      .i_data(bc_data),
      .i_dq(i_dq),
      .o_pins(pins),
      .o_done(bc_done),
      .o_rdata(bc_rd)
   );

   // Sequence length per command; every array change is unlocked
   always_comb
   begin
      unique case (req_r.op)
         FSP_OP_PROG: seq_len = 3'd4;
         FSP_OP_SEC, FSP_OP_BLK, FSP_OP_CHIP: seq_len = 3'd6;
         FSP_OP_QRY: seq_len = req_r.vendor ? 3'd3 : 3'd1;
         FSP_OP_EXIT: seq_len = req_r.vendor ? 3'd3 : 3'd1;
         FSP_OP_ID: seq_len = 3'd3;
         default: seq_len = 3'd1;
      endcase
   end

   // Address/data for step idx; upper byte driven zero except in the program data step
   always_comb
   begin
      bc_wr = (st_r == FSP_SEQ);
      bc_addr = req_r.addr;
      bc_data = req_r.data;
      if (st_r == FSP_SEQ && !(req_r.op == FSP_OP_PROG && idx_r == 3'd3))
      begin
         bc_data = 16'h0000;
         if (seq_len == 3'd1)
         begin
            bc_addr = (req_r.op == FSP_OP_QRY) ? ADR_55 : ADR_ZERO;
            bc_data[7:0] = (req_r.op == FSP_OP_QRY) ? CMD_QRY : CMD_EXIT;
         end
         else
         begin
            unique case (idx_r)
               3'd0, 3'd3:
               begin
                  bc_addr = ADR_5555;
                  bc_data[7:0] = CMD_AA;
               end
               3'd1, 3'd4:
               begin
                  bc_addr = ADR_2AAA;
                  bc_data[7:0] = CMD_55;
               end
               3'd2:
               begin
                  bc_addr = ADR_5555;
                  unique case (req_r.op)
                     FSP_OP_PROG: bc_data[7:0] = CMD_PROG;
                     FSP_OP_ID: bc_data[7:0] = CMD_ID;
                     FSP_OP_QRY: bc_data[7:0] = CMD_QRY;
                     FSP_OP_EXIT: bc_data[7:0] = CMD_EXIT;
                     default: bc_data[7:0] = CMD_ERS;
                  endcase
               end
               default:
               begin
                  bc_addr = (req_r.op == FSP_OP_CHIP) ? ADR_5555 : req_r.addr;
                  bc_data[7:0] = (req_r.op == FSP_OP_SEC) ? CMD_SEC :
                     (req_r.op == FSP_OP_BLK) ? CMD_BLK : CMD_CHIP;
               end
            endcase
         end
      end
   end

   // Busy view of a status word: toggle bit still moving
   assign busy_view = (bc_rd[BIT_TOG] != prev_r[BIT_TOG]);

   // Main control: issue sequence, poll, confirm, settle
   always_comb
   begin
      st_nxt = st_r;
      req_nxt = req_r;
      idx_nxt = idx_r;
      conf_nxt = conf_r;
      prev_nxt = prev_r;
      first_nxt = first_r;
      wait_nxt = wait_r;
      go_nxt = 1'b0;
      done_nxt = 1'b0;
      fail_nxt = fail_r;
      rdat_nxt = rdat_r;
      unique case (st_r)
         FSP_IDLE:
         begin
            if (i_req_valid)
            begin
               req_nxt = i_req;
               idx_nxt = 3'd0;
               fail_nxt = 1'b0;
               go_nxt = 1'b1;
               st_nxt = (i_req.op == FSP_OP_READ) ? FSP_RD : FSP_SEQ;
            end
         end
         FSP_SEQ:
         begin
            if (bc_done)
            begin
               go_nxt = 1'b1;
               if (idx_r == seq_len - 3'd1)
               begin
                  // Status valid once final strobe rose
                  first_nxt = 1'b1;
                  st_nxt = (req_r.op inside {FSP_OP_PROG, FSP_OP_SEC,
                     FSP_OP_BLK, FSP_OP_CHIP}) ? FSP_POLL : FSP_IDLE;
                  go_nxt = (st_nxt == FSP_POLL);
                  done_nxt = (st_nxt == FSP_IDLE);
               end
               else
                  idx_nxt = idx_r + 3'd1;
            end
         end
         FSP_POLL:
         begin
            if (bc_done)
            begin
               prev_nxt = bc_rd;
               first_nxt = 1'b0;
               go_nxt = 1'b1;
               if (!first_r && !busy_view)
               begin
                  conf_nxt = 2'd0;
                  st_nxt = FSP_CONF;
               end
            end
         end
         FSP_CONF:
         begin
            // Two more reads must agree before done
            if (bc_done)
            begin
               prev_nxt = bc_rd;
               if (busy_view)
               begin
                  // Back to polling with a fresh read, else it stalls
                  go_nxt = 1'b1;
                  st_nxt = FSP_POLL;
               end
               else if (conf_r == 2'(EXTRA_READS - 1))
               begin
                  // Poll bit: erase must read 1 program true data
                  if (req_r.op == FSP_OP_PROG)
                     fail_nxt = bc_rd[BIT_POLL] != req_r.data[BIT_POLL];
                  else
                     fail_nxt = !bc_rd[BIT_POLL];
                  wait_nxt = 16'(SETTLE);
                  st_nxt = FSP_SETTLE;
               end
               else
               begin
                  conf_nxt = conf_r + 2'd1;
                  go_nxt = 1'b1;
               end
            end
         end
         FSP_SETTLE:
         begin
            // Rest of bus valid only after settle time
            if (wait_r == 16'h0000)
            begin
               done_nxt = 1'b1;
               st_nxt = FSP_IDLE;
            end
            else
               wait_nxt = wait_r - 16'h0001;
         end
         FSP_RD:
         begin
            // Plain, ID or query table read
            if (bc_done)
            begin
               rdat_nxt = bc_rd;
               done_nxt = 1'b1;
               st_nxt = FSP_IDLE;
            end
         end
      endcase
      // Ready registered so the output comes from a flip-flop
      ready_nxt = (st_nxt == FSP_IDLE);
   end

   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         st_r <= FSP_IDLE;
         req_r <= '0;
         idx_r <= 3'd0;
         conf_r <= 2'd0;
         prev_r <= 16'h0000;
         first_r <= 1'b0;
         wait_r <= 16'h0000;
         go_r <= 1'b0;
         done_r <= 1'b0;
         fail_r <= 1'b0;
         rdat_r <= 16'h0000;
         ready_r <= 1'b1;
      end
      else
      begin
         st_r <= st_nxt;
         req_r <= req_nxt;
         idx_r <= idx_nxt;
         conf_r <= conf_nxt;
         prev_r <= prev_nxt;
         first_r <= first_nxt;
         wait_r <= wait_nxt;
         go_r <= go_nxt;
         done_r <= done_nxt;
         fail_r <= fail_nxt;
         rdat_r <= rdat_nxt;
         ready_r <= ready_nxt;
      end
   end

   // Outputs straight from flip-flops
   assign o_req_ready = ready_r;
   assign o_done = done_r;
   assign o_fail = fail_r;
   assign o_rdata = rdat_r;
   assign o_ce_n = pins.ce_n;
   assign o_oe_n = pins.oe_n;
   assign o_we_n = pins.we_n;
   assign o_dq_oe = pins.dq_oe;
   assign o_addr = pins.addr;
   assign o_dq = pins.dq;

   chk_settle_len: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      (st_r == FSP_CONF && st_nxt == FSP_SETTLE) |=> (st_r == FSP_SETTLE)
      [*8])
      else $error("settle wait too short");
   chk_seq_unlock: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      (st_r == FSP_SEQ && idx_r == 3'd0 && seq_len != 3'd1 && go_r)
      |-> bc_addr == ADR_5555 && bc_data[7:0] == CMD_AA)
      else $error("sequence does not open with unlock");
   chk_upper_zero: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      (st_r == FSP_SEQ && req_r.op != FSP_OP_PROG) |-> bc_data[15:8] == 8'h00)
      else $error("upper byte driven in command");
   chk_conf_count: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      (st_r == FSP_CONF && st_nxt == FSP_SETTLE) |-> conf_r == 2'd1)
      else $error("completion accepted without two reads");
   chk_poll_start: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      (st_r == FSP_SEQ && st_nxt == FSP_POLL) |-> idx_r == seq_len - 3'd1)
      else $error("polling before last strobe");
   chk_exit_done: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      (st_r == FSP_SEQ && req_r.op == FSP_OP_EXIT && st_nxt == FSP_IDLE)
      |=> done_r)
      else $error("exit not reported");
   cov_prog: cover property (@(posedge i_ref_clk)
      st_r == FSP_SETTLE && req_r.op == FSP_OP_PROG);
   cov_erase: cover property (@(posedge i_ref_clk)
      st_r == FSP_SETTLE && req_r.op == FSP_OP_CHIP);
   cov_query: cover property (@(posedge i_ref_clk)
      done_r && req_r.op == FSP_OP_QRY);
endmodule // fsp_host

// ### verif/fsp_flash_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Behavioural flash device with status bits
// ----------------------------------------
module fsp_flash_model
   import fsp_pkg::*;
#(
   // Identity codes: arbitrary values
   parameter logic [15:0] MAKER_ID = 16'h0a5a,
   parameter logic [15:0] DEV_ID = 16'h1c3c
)
(
   input wire logic i_ce_n,
   input wire logic i_oe_n,
   input wire logic i_we_n,
   input wire logic [17:0] i_addr,
   input wire logic [15:0] i_dq,
   input var int i_busy_ns,
   input wire logic i_bad,
   output logic [15:0] o_dq
);
   logic [15:0] mem [logic [17:0]];
   logic [15:0] rd_r, pdat_r;
   logic [17:0] pa_r;
   logic busy_r, ers_r, tog_r;
   logic wr_act;
   logic [1:0] mode_r; // 0 read, 1 id, 2 query
   int step_r;
   realtime t_fall;
   event go;

   initial
   begin
      {busy_r, ers_r, tog_r, mode_r, rd_r, pdat_r, pa_r} = '0;
      step_r = 0;
      t_fall = 0.0;
   end

   // Unlock decoder; low byte only, upper address bits ignored
   task automatic cmd(input logic [17:0] a, input logic [15:0] dw);
      logic u5, u2;
      logic [7:0] d;
      d = dw[7:0];
      u5 = (a[14:0] == ADR_5555[14:0]);
      u2 = (a[14:0] == ADR_2AAA[14:0]);
      case (step_r)
         0: if (u5 && d == CMD_AA) step_r = 1;
            else if (d == CMD_EXIT) mode_r = 0;
            else if (a[14:0] == ADR_55[14:0] && d == CMD_QRY)
               mode_r = 2;
         1: step_r = (u2 && d == CMD_55) ? 2 : 0;
         2: begin
            step_r = (u5 && d == CMD_PROG) ? 3 : (u5 && d == CMD_ERS) ? 4 : 0;
            if (u5 && d == CMD_ID) mode_r = 1;
            if (u5 && d == CMD_QRY) mode_r = 2;
            if (u5 && d == CMD_EXIT) mode_r = 0;
         end
         3: begin
            {pa_r, pdat_r, ers_r, busy_r, step_r} = {a, dw, 1'b0, 1'b1, 32'd0};
            -> go;
         end
         4: step_r = (u5 && d == CMD_AA) ? 5 : 0;
         5: step_r = (u2 && d == CMD_55) ? 6 : 0;
         default: begin
            step_r = 0;
            if (d == CMD_SEC || d == CMD_BLK || (u5 && d == CMD_CHIP))
            begin
               {ers_r, busy_r} = 2'b11;
               -> go;
            end
         end
      endcase
   endtask

   // Write phase: select and strobe low, gate high; ends when either rises
   always_comb wr_act = !i_ce_n && !i_we_n && i_oe_n;

   // Glitch filter: time the write phase
   always @(posedge wr_act) t_fall = $realtime;

   // Writes land as the phase ends; nothing is taken while busy
   always @(negedge wr_act)
   begin
      if (($realtime - t_fall >= 5.0) && !busy_r)
      begin
         cmd(i_addr, i_dq);
      end
   end

   // Array finishes; every erase blanks the whole array, no sector map
   always @(go)
   begin
      #(i_busy_ns);
      if (ers_r) mem.delete();
      else mem[pa_r] = pdat_r ^ {8'h00, i_bad, 7'h00};
      busy_r = 1'b0;
   end

   // Each read access latches one word; bit 6 flips per access while busy
   always @(negedge i_oe_n or negedge i_ce_n)
   begin
      // Let the address settle; also one access per select and gate fall
      #1;
      if (!i_oe_n && !i_ce_n)
      begin
         if (busy_r)
         begin
            tog_r = ~tog_r;
            rd_r = {8'h5a, ers_r ? 1'b0 : ~pdat_r[7], tog_r,
               6'h2d};
         end
         else if (mode_r == 1) rd_r = (i_addr == 0) ? MAKER_ID :
            (i_addr == 1) ? DEV_ID : 16'h0000;
         else if (mode_r == 2) rd_r = (i_addr == 18'h10) ? 16'h0051 :
            (i_addr == 18'h12) ? 16'h0059 : 16'h0000;
         else rd_r = mem.exists(i_addr) ? mem[i_addr] : 16'hffff;
      end
   end

   // Released bus shows the inverse of the last word, never a held value
   always_comb o_dq = (!i_ce_n && !i_oe_n) ? rd_r : ~rd_r;
endmodule // fsp_flash_model

// ### verif/tb_fsp_host.sv
`timescale 1ns/1ps
// ----------------------------------------
// Self-checking bench for the flash host
// ----------------------------------------
module tb_fsp_host;
   import fsp_pkg::*;
   typedef struct packed {
      logic cr;
      logic [15:0] rd;
      logic cf;
      logic fl;
   } fsp_exp_t;
   localparam logic [15:0] MK = 16'h0a5a; // Arbitrary value
   localparam logic [15:0] DV = 16'h1c3c; // Arbitrary value
   logic i_ref_clk, i_rst, i_req_valid, o_req_ready, o_done, o_fail;
   logic o_ce_n, o_oe_n, o_we_n, o_dq_oe, bad;
   logic [15:0] i_dq, o_rdata, o_dq, fl_dq, d;
   logic [17:0] o_addr, a;
   logic [31:0] rng;
   fsp_req_t i_req;
   fsp_op_t k;
   fsp_exp_t exp_q[$];
   fsp_exp_t e;
   int busy_ns, n_fail, cmp_count, n_done, cyc;

   // Wire level: host drives the bus only while its enable is high
   always_comb i_dq = o_dq_oe ? o_dq : fl_dq;

   initial
   begin
      i_ref_clk = 1'b0;
      forever #20 i_ref_clk = ~i_ref_clk;
   end

   fsp_host u_fsp_host (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
      .i_req_valid(i_req_valid), .i_req(i_req), .i_dq(i_dq),
      .o_req_ready(o_req_ready), .o_done(o_done), .o_fail(o_fail),
      .o_rdata(o_rdata), .o_ce_n(o_ce_n), .o_oe_n(o_oe_n), .o_we_n(o_we_n),
      .o_dq_oe(o_dq_oe), .o_addr(o_addr), .o_dq(o_dq));
   fsp_flash_model #(.MAKER_ID(MK), .DEV_ID(DV)) u_fsp_flash_model (
      .i_ce_n(o_ce_n), .i_oe_n(o_oe_n), .i_we_n(o_we_n), .i_addr(o_addr),
      .i_dq(o_dq), .i_busy_ns(busy_ns), .i_bad(bad), .o_dq(fl_dq));

   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction

   task automatic check(input logic [15:0] got, input logic [15:0] want,
      input string what);
      cmp_count++;
      if (got !== want)
      begin
         n_fail++;
         $display("mismatch at %0t: %s got %h want %h", $time, what, got,
            want);
      end
   endtask

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // One request; its expected outcome is noted before it is sent
   task automatic op(input fsp_op_t kk, input logic [17:0] aa,
      input logic [15:0] dd, input logic v, input fsp_exp_t ex);
      int n;
      n = n_done;
      exp_q.push_back(ex);
      @(negedge i_ref_clk);
      i_req_valid = 1'b1;
      i_req = '{kk, aa, dd, v};
      while (o_req_ready !== 1'b1) @(negedge i_ref_clk);
      @(negedge i_ref_clk);
      i_req_valid = 1'b0;
      while (n_done == n) @(negedge i_ref_clk);
   endtask

   // Scoreboard: each done pulse retires the oldest note
   always @(negedge i_ref_clk)
   begin
      if (o_done === 1'b1)
      begin
         if (exp_q.size() == 0) check(16'h1, 16'h0, "stray done");
         else
         begin
            e = exp_q.pop_front();
            if (e.cr) check(o_rdata, e.rd, "read data");
            if (e.cf) check({15'h0, o_fail}, {15'h0, e.fl}, "status");
         end
         n_done++;
      end
   end

   // Hang guard: a few thousand cycles are expected at most
   always @(posedge i_ref_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_fail++;
         $display("mismatch at %0t: timeout", $time);
         print_verdict();
      end
   end

   initial
   begin
      {i_rst, i_req_valid, bad, a, d} = {1'b1, 1'b0, 1'b0, 34'h0};
      i_req = '0;
      {busy_ns, n_fail, cmp_count, n_done, cyc} = {32'd2000, 128'd0};
      rng = 32'h05e7;
      repeat (6) @(negedge i_ref_clk);
      check({13'h0, o_ce_n, o_oe_n, o_we_n}, 16'h0007, "idle pins");
      i_rst = 1'b0;
      op(FSP_OP_READ, 18'h0, 16'h0, 1'b0, '{1'b1, 16'hffff, 1'b0, 1'b0});
      // Programs, prompt and slow, each read back
      for (int i = 0; i < 4; i++)
      begin
         rng = xs(rng);
         {d, a} = {rng[31:16], rng[17:0]};
         busy_ns = i[0] ? 20000 : 2000;
         op(FSP_OP_PROG, a, d, 1'b0, '{1'b0, 16'h0, 1'b1, 1'b0});
         op(FSP_OP_READ, a, 16'h0, 1'b0, '{1'b1, d, 1'b0, 1'b0});
      end
      $display("test program done");
      bad = 1'b1;
      op(FSP_OP_PROG, a, d, 1'b0, '{1'b0, 16'h0, 1'b1, 1'b1});
      bad = 1'b0;
      $display("test failed program done");
      // Every erase kind blanks the programmed word
      for (int i = 0; i < 3; i++)
      begin
         k = (i == 0) ? FSP_OP_SEC : (i == 1) ? FSP_OP_BLK : FSP_OP_CHIP;
         op(FSP_OP_PROG, a, d, 1'b0, '{1'b0, 16'h0, 1'b1, 1'b0});
         op(k, a, 16'h0, 1'b0, '{1'b0, 16'h0, 1'b1, 1'b0});
         op(FSP_OP_READ, a, 16'h0, 1'b0, '{1'b1, 16'hffff, 1'b0, 1'b0});
      end
      $display("test erase done");
      op(FSP_OP_ID, 18'h0, 16'h0, 1'b1, '0);
      op(FSP_OP_READ, 18'h0, 16'h0, 1'b0, '{1'b1, MK, 1'b0, 1'b0});
      op(FSP_OP_READ, 18'h1, 16'h0, 1'b0, '{1'b1, DV, 1'b0, 1'b0});
      op(FSP_OP_EXIT, 18'h0, 16'h0, 1'b0, '0);
      op(FSP_OP_READ, 18'h1, 16'h0, 1'b0, '{1'b1, 16'hffff, 1'b0, 1'b0});
      $display("test id mode done");
      // Both query entries, each left by the other exit form
      for (int v = 0; v < 2; v++)
      begin
         op(FSP_OP_QRY, 18'h0, 16'h0, v[0], '0);
         op(FSP_OP_READ, 18'h10, 16'h0, 1'b0, '{1'b1, 16'h0051, 1'b0, 1'b0});
         op(FSP_OP_READ, 18'h12, 16'h0, 1'b0, '{1'b1, 16'h0059, 1'b0, 1'b0});
         op(FSP_OP_EXIT, 18'h0, 16'h0, ~v[0], '0);
         op(FSP_OP_READ, 18'h10, 16'h0, 1'b0, '{1'b1, 16'hffff, 1'b0, 1'b0});
      end
      $display("test query mode done");
      print_verdict();
   end
endmodule // tb_fsp_host
